// >>> design/tmr_int_unit.sv
// Purpose: system timer and priority interrupt logic of the processor
// Assumes: pins are asynchronous to i_clk; the core presents instruction
//          boundaries, system control register moves and clear-bit requests
// Notes:   general registers are never saved here; the handler does that
`timescale 1ns/1ps
module tmr_int_unit
    import tmr_int_pkg::*;
(
    // clock and reset
    input  wire  logic                 i_clk,
    input  wire  logic                 i_nrst,
    // pins
    input  wire  logic                 i_tick_n,
    input  wire  logic [NUM_LEVELS-1:0] i_req_n,
    input  wire  logic                 i_trap_n,
    // fault reports from the channel
    input  wire  logic                 i_chan_parity_err,
    input  wire  logic                 i_chan_timeout,
    // system control register moves
    input  wire  logic                 i_sreg_wr,
    input  wire  logic                 i_sreg_rd,
    input  wire  logic [3:0]           i_sreg_num,
    input  wire  logic [31:0]          i_sreg_wdata,
    input  wire  logic                 i_clr_bit,
    input  wire  logic [4:0]           i_clr_pos,
    output logic       [31:0]          o_sreg_rdata,
    // instruction sequencing
    input  wire  logic                 i_boundary,
    input  wire  logic                 i_no_intr,
    input  wire  logic                 i_in_check,
    input  prog_status_s               i_cur_ps,
    input  prog_status_s               i_new_ps,
    input  wire  logic                 i_restore,
    input  prog_status_s               i_restore_ps,
    // results to the core
    output logic                       o_stall,
    output logic                       o_take,
    output logic       [2:0]           o_take_level,
    output prog_status_s               o_old_ps,
    output logic                       o_load_ps,
    output prog_status_s               o_load_ps_val,
    output logic                       o_mcheck,
    output logic       [15:0]          o_ctrl_word
);

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    localparam int NPINS = NUM_LEVELS + 2;

    logic [NPINS-1:0] pin_raw;
    logic [NPINS-1:0] pin_lvl_r;
    logic [NPINS-1:0] pin_prev_r;

    assign pin_raw = {i_trap_n, i_tick_n, i_req_n};

    genvar g;
    generate
        for (g = 0; g < NPINS; g++) begin : g_sync
            logic [SYNC_STAGES-1:0] sh_r;
            always_ff @(posedge i_clk) begin
                if (!i_nrst) begin
                    sh_r          <= '1;
                    pin_lvl_r[g]  <= 1'b1;
                    pin_prev_r[g] <= 1'b1;
                end else begin
                    sh_r <= {sh_r[SYNC_STAGES-2:0], pin_raw[g]};
                    // a change counts only when the last two stages agree
                    if (sh_r[1] == sh_r[2])
                        pin_lvl_r[g] <= sh_r[2];
                    pin_prev_r[g] <= pin_lvl_r[g];
                end
            end
        end
    endgenerate

    wire [NUM_LEVELS-1:0] ext_req   = ~pin_lvl_r[NUM_LEVELS-1:0];  // R22
    wire                  tick_fall = pin_prev_r[NUM_LEVELS]
                                      & ~pin_lvl_r[NUM_LEVELS];  // R23 R27
    wire                  trap_fall = pin_prev_r[NUM_LEVELS+1]
                                      & ~pin_lvl_r[NUM_LEVELS+1];

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [31:0]  reload_r;
    logic [31:0]  count_r;
    logic [7:0]   tstat_r;
    logic [15:0]  reqbuf_r;
    logic [15:0]  cword_r;
    tmr_state_e   tstate_r;
    tmr_state_e   tstate_nxt;

    // ----------------------------------------------------------------
    // countdown sequencer
    // ----------------------------------------------------------------
    // the tick edge first raises the stall, the count moves one cycle
    // later so no instruction can see a half-updated countdown
    always_comb begin
        case (tstate_r)
            T_IDLE:  tstate_nxt = tick_fall ? T_HOLD : T_IDLE;  // R2
            T_HOLD:  tstate_nxt = T_STEP;
            T_STEP:  tstate_nxt = T_IDLE;
            default: tstate_nxt = T_IDLE;
        endcase
    end

    wire step    = (tstate_r == T_HOLD);
    wire expire  = step & (count_r == 32'h0000_0001);  // R3
    wire enabled = tstat_r[TSTAT_ENABLE_IDX];
    wire alarm_en = expire & enabled;                   // R7
    wire [2:0] tprio = tstat_r[TSTAT_PRIO_LSB +: 3];

    wire [31:0] count_step = expire ? reload_r : count_r - 32'h0000_0001;  // R1 R3

    // ----------------------------------------------------------------
    // register write decode
    // ----------------------------------------------------------------
    wire wr_reload = i_sreg_wr & (i_sreg_num == SREG_RELOAD);
    wire wr_count  = i_sreg_wr & (i_sreg_num == SREG_COUNTDOWN);
    wire wr_tstat  = i_sreg_wr & (i_sreg_num == SREG_TSTATUS);
    wire wr_reqbuf = i_sreg_wr & (i_sreg_num == SREG_REQ_BUF);
    wire wr_cword  = i_sreg_wr & (i_sreg_num == SREG_CTRL_WORD);

    // clear-bit position uses msb-first numbering
    wire [4:0]  clr_idx  = 5'd31 - i_clr_pos;
    wire [31:0] clr_mask = i_clr_bit ? ~(32'h0000_0001 << clr_idx) : 32'hffff_ffff;
    wire clr_tstat  = i_clr_bit & (i_sreg_num == SREG_TSTATUS);
    wire clr_reqbuf = i_clr_bit & (i_sreg_num == SREG_REQ_BUF);
    wire clr_cword  = i_clr_bit & (i_sreg_num == SREG_CTRL_WORD);

    // ----------------------------------------------------------------
    // timer status
    // ----------------------------------------------------------------
    wire [7:0] tstat_base = wr_tstat  ? i_sreg_wdata[7:0] :
                            clr_tstat ? (tstat_r & clr_mask[7:0]) : tstat_r;  // R8

    // a pending flag still set when the next enabled alarm lands
    // means one alarm went unserviced
    wire ovf_set = alarm_en & tstat_r[TSTAT_PEND_IDX];  // R9

    logic [7:0] tstat_nxt;
    always_comb begin
        tstat_nxt = tstat_base;
        // hardware sets win over a clear in the same cycle
        if (alarm_en)
            tstat_nxt[TSTAT_PEND_IDX] = 1'b1;  // R5 R6
        if (ovf_set)
            tstat_nxt[TSTAT_OVF_IDX] = 1'b1;   // R9
        tstat_nxt[7] = 1'b0;                // reserved bit 24
        tstat_nxt[3] = 1'b0;                // reserved bit 28
    end

    // ----------------------------------------------------------------
    // software request buffer
    // ----------------------------------------------------------------
    wire [15:0] reqbuf_base = wr_reqbuf ? i_sreg_wdata[15:0] :
                              clr_reqbuf ? (reqbuf_r & clr_mask[15:0]) : reqbuf_r;

    logic [15:0] reqbuf_nxt;
    always_comb begin
        reqbuf_nxt = reqbuf_base;
        if (alarm_en && tprio != PRIO_NONE)  // R4 R10 R11
            reqbuf_nxt[REQ_LVL0_IDX - int'(tprio)] = 1'b1;
        reqbuf_nxt[8:0] = 9'h000;            // only levels 0-6 exist  R20
    end

    // ----------------------------------------------------------------
    // priority arbitration
    // ----------------------------------------------------------------
    logic [NUM_LEVELS-1:0] req_lvl;
    logic [2:0]            best_lvl;
    logic                  any_req;

    always_comb begin
        best_lvl = PRIO_NONE;
        any_req  = 1'b0;
        for (int i = 0; i < NUM_LEVELS; i++)
            req_lvl[i] = ext_req[i] | reqbuf_r[REQ_LVL0_IDX - i];  // R15 R24
        for (int i = NUM_LEVELS - 1; i >= 0; i--) begin
            if (req_lvl[i]) begin
                best_lvl = 3'(i);  // level 0 wins  R19
                any_req  = 1'b1;
            end
        end
    end

    wire [2:0] cur_prio = cword_r[CW_PRIO_LSB +: 3];
    wire       masked   = cword_r[CW_MASK_IDX];                        // R26
    wire       above    = any_req & (best_lvl < cur_prio);            // R13 R25
    // error handlers leave all requests pending
    wire       window   = i_boundary & ~i_no_intr & ~i_in_check;      // R14
    wire       take     = window & above & ~masked & ~i_restore;      // R13

    // ----------------------------------------------------------------
    // control word
    // ----------------------------------------------------------------
    wire [15:0] cword_nxt = take      ? i_new_ps.ctrl_word :         // R16
                            i_restore ? i_restore_ps.ctrl_word :     // R18
                            wr_cword  ? i_sreg_wdata[15:0] :
                            clr_cword ? (cword_r & clr_mask[15:0]) : cword_r;

    // ----------------------------------------------------------------
    // register read mux
    // ----------------------------------------------------------------
    wire [31:0] rd_val = (i_sreg_num == SREG_RELOAD)    ? reload_r :
                         (i_sreg_num == SREG_COUNTDOWN) ? count_r :
                         (i_sreg_num == SREG_TSTATUS)   ? {24'h000000, tstat_r} :
                         (i_sreg_num == SREG_REQ_BUF)   ? {16'h0000, reqbuf_r} :
                         (i_sreg_num == SREG_CTRL_WORD) ? {16'h0000, cword_r} :
                                                        32'h0000_0000;

    wire mcheck_ev = trap_fall | i_chan_parity_err | i_chan_timeout;  // R21

    // ----------------------------------------------------------------
    // state update
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            tstate_r <= T_IDLE;
            reload_r <= RELOAD_RST;
            count_r  <= COUNTDOWN_RST;
            tstat_r  <= TSTATUS_RST;  // R7
            reqbuf_r <= REQ_BUF_RST;
            cword_r  <= CTRL_WORD_RST;
        end else begin
            tstate_r <= tstate_nxt;
            if (wr_reload)
                reload_r <= i_sreg_wdata;  // R12
            // tick step wins; no instruction runs while it is stalled
            if (step)
                count_r <= count_step;    // R1
            else if (wr_count)
                count_r <= i_sreg_wdata;
            tstat_r  <= tstat_nxt;
            reqbuf_r <= reqbuf_nxt;
            cword_r  <= cword_nxt;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            o_stall       <= 1'b0;
            o_take        <= 1'b0;
            o_take_level  <= PRIO_NONE;
            o_old_ps      <= '0;
            o_load_ps     <= 1'b0;
            o_load_ps_val <= '0;
            o_mcheck      <= 1'b0;
            o_sreg_rdata  <= 32'h0000_0000;
            o_ctrl_word   <= CTRL_WORD_RST;
        end else begin
            o_stall  <= (tstate_nxt != T_IDLE);  // R2
            o_take   <= take;
            o_mcheck <= mcheck_ev;               // R21
            if (take) begin
                o_take_level <= best_lvl;
                // the control word lives here, so the core's copy is not trusted
                o_old_ps     <= '{instr_ptr: i_cur_ps.instr_ptr, cs: i_cur_ps.cs,
                                  ctrl_word: cword_r};  // R16
            end
            // new status keeps the current condition flags
            o_load_ps <= take | i_restore;
            if (take)
                o_load_ps_val <= '{instr_ptr: i_new_ps.instr_ptr, cs: i_cur_ps.cs,
                                   ctrl_word: i_new_ps.ctrl_word};  // R16
            else if (i_restore)
                o_load_ps_val <= i_restore_ps;   // R18
            if (i_sreg_rd)
                o_sreg_rdata <= rd_val;
            o_ctrl_word <= cword_nxt;
        end
    end

endmodule : tmr_int_unit

// >>> design/tmr_int_pkg.sv
// Purpose: constants and carriers for the timer and priority interrupt unit
// Assumes: big-endian bit numbers in the register view (bit 0 is the msb)
// Notes:   all offsets are system control register numbers, not byte addresses
// What this block does
// R1: 32-bit countdown decrements once per tick pulse
// R2: stall instructions while the countdown updates
// R3: at 1 to 0, reload and start alarm
// R4: enabled alarm sets request buffer bit at priority
// R5: alarm updates status, reload register untouched
// R6: pending flag set only by enabled alarm
// R7: enable gates alarm flags and requests, not the count, resets to zero
// R8: clear-bit instruction clears the pending flag
// R9: second alarm before clear sets overflow flag
// R10: timer priority seven sets no request bit
// R11: software programs timer priority zero to six
// R12: reload write never changes running countdown
// R13: take only above processor priority and unmasked
// R14: take only at interruptible instruction boundaries
// R15: external lines and buffer bits treated alike
// R16: taking saves status, loads new pointer, control
// R17: service routine saves its own general registers
// R18: restore instruction reloads pointer, flags, control
// R19: processor priority three bits, zero highest
// R20: requests exist only on levels zero to six
// R21: faults and trap pin raise machine check
// R22: request level fixed by wired input line
// R23: countdown steps on tick falling edge
// R24: buffer bits 16-22 request levels 0-6, sticky
// R25: priority in control bits 29-31, ignore lower-or-equal
// R26: control bit 23 masks interrupts, leaving pending
// R27: synchronise tick, count each edge once
package tmr_int_pkg;

    // ----------------------------------------------------------------
    // register numbers
    // ----------------------------------------------------------------
    localparam logic [3:0] SREG_RELOAD    = 4'h6;
    localparam logic [3:0] SREG_COUNTDOWN = 4'h7;
    localparam logic [3:0] SREG_TSTATUS   = 4'h8;
    localparam logic [3:0] SREG_REQ_BUF   = 4'hc;
    localparam logic [3:0] SREG_CTRL_WORD = 4'he;

    // ----------------------------------------------------------------
    // field positions as lsb-first indices
    // ----------------------------------------------------------------
    localparam int TSTAT_ENABLE_IDX = 6; // bit 25
    localparam int TSTAT_PEND_IDX   = 5; // bit 26
    localparam int TSTAT_OVF_IDX    = 4; // bit 27
    localparam int TSTAT_PRIO_LSB   = 0; // bits 29-31
    localparam int REQ_LVL0_IDX   = 15;  // bit 16, level n at 15-n
    localparam int CW_MASK_IDX    = 8;   // bit 23
    localparam int CW_PRIO_LSB    = 0;   // bits 29-31

    // ----------------------------------------------------------------
    // reset values and sizes
    // ----------------------------------------------------------------
    localparam logic [31:0] RELOAD_RST    = 32'h0000_0000;
    localparam logic [31:0] COUNTDOWN_RST = 32'h0000_0000;
    localparam logic [7:0]  TSTATUS_RST   = 8'h00;
    localparam logic [15:0] REQ_BUF_RST   = 16'h0000;
    localparam logic [15:0] CTRL_WORD_RST = 16'h0000;
    localparam logic [2:0]  PRIO_NONE     = 3'h7;
    localparam int          NUM_LEVELS    = 7;
    localparam int          SYNC_STAGES   = 3;

    // ----------------------------------------------------------------
    // program status carrier
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [31:0] instr_ptr;
        logic [15:0] cs;
        logic [15:0] ctrl_word;
    } prog_status_s;

    typedef enum logic [1:0] {
        T_IDLE = 2'b00,
        T_HOLD = 2'b01,
        T_STEP = 2'b11
    } tmr_state_e;

endpackage : tmr_int_pkg

// >>> tb/tmr_int_unit_chk.sv
// Purpose: port-level checks of the timer and priority interrupt unit
// Assumes: one clock domain, synchronous active-low reset
// Notes:   bound from the bench top file
`timescale 1ns/1ps
module tmr_int_unit_chk
    import tmr_int_pkg::*;
(
    // clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_nrst,
    // watched inputs
    input  wire logic         i_boundary,
    input  wire logic         i_no_intr,
    input  wire logic         i_in_check,
    input  wire logic         i_restore,
    input  wire logic         i_chan_parity_err,
    input  wire logic         i_chan_timeout,
    input  prog_status_s      i_cur_ps,
    input  prog_status_s      i_new_ps,
    input  prog_status_s      i_restore_ps,
    // watched outputs
    input  wire logic         o_stall,
    input  wire logic         o_take,
    input  wire logic [2:0]   o_take_level,
    input  prog_status_s      o_old_ps,
    input  wire logic         o_load_ps,
    input  prog_status_s      o_load_ps_val,
    input  wire logic         o_mcheck,
    input  wire logic [15:0]  o_ctrl_word
);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    // the mask comes from the registered control word, as the block sees it
    wire take_ok = i_boundary & !i_no_intr & !i_in_check & !i_restore & !o_ctrl_word[CW_MASK_IDX];

    AST_STALL_TWO: assert property ($rose(o_stall) |-> o_stall [*2] ##1 !o_stall)
        else $error("stall not two cycles long");
    AST_TAKE_GATE: assert property (o_take |-> $past(take_ok))
        else $error("take outside an open boundary");
    AST_TAKE_PRIO: assert property (o_take |-> o_take_level < $past(o_ctrl_word[2:0]))
        else $error("take not above processor priority");
    AST_NO_LVL7: assert property (o_take |-> o_take_level != PRIO_NONE)
        else $error("take at level seven");
    AST_OLD_PS: assert property (o_take |->
        o_old_ps.instr_ptr == $past(i_cur_ps.instr_ptr) && o_old_ps.cs == $past(i_cur_ps.cs)
        && o_old_ps.ctrl_word == $past(o_ctrl_word))
        else $error("old status not saved");
    AST_NEW_PS: assert property (o_take |-> o_load_ps &&
        o_load_ps_val.instr_ptr == $past(i_new_ps.instr_ptr)
        && o_load_ps_val.cs == $past(i_cur_ps.cs)
        && o_ctrl_word == $past(i_new_ps.ctrl_word))
        else $error("new status not loaded");
    AST_RESTORE: assert property (i_restore |=> o_load_ps &&
        o_load_ps_val == $past(i_restore_ps) && o_ctrl_word == $past(i_restore_ps.ctrl_word))
        else $error("restore did not load status");
    AST_MCHECK: assert property ((i_chan_parity_err || i_chan_timeout) |=> o_mcheck)
        else $error("fault gave no machine check");

    COV_TAKE: cover property (o_take);
    COV_RESTORE: cover property (i_restore ##1 o_load_ps);
    COV_STALL: cover property ($rose(o_stall));
    COV_MCHECK: cover property (o_mcheck);
endmodule : tmr_int_unit_chk

// >>> tb/ext_src.sv
// Purpose: system components on the far side: tick source, request lines, trap pin
// Assumes: pins are active low and idle high
// Notes:   low phases are long so the block's synchronisers see every edge once
`timescale 1ns/1ps
module ext_src
    import tmr_int_pkg::*;
(
    input  wire logic                  i_clk,
    output logic                       o_tick_n,
    output logic [NUM_LEVELS-1:0]      o_req_n,
    output logic                       o_trap_n
);
    // ------------------------------------------------------------
    // pin drivers
    // ------------------------------------------------------------
    initial begin
        o_tick_n = 1'b1;
        o_req_n  = '1;
        o_trap_n = 1'b1;
    end

    task automatic tick();
        @(posedge i_clk);
        #1 o_tick_n = 1'b0;
        repeat (10) @(posedge i_clk);
        #1 o_tick_n = 1'b1;
        repeat (10) @(posedge i_clk);
    endtask : tick

    // one line per level, the wiring alone fixes the level
    task automatic set_req(input logic [NUM_LEVELS-1:0] v);
        @(posedge i_clk);
        #1 o_req_n = v;
    endtask : set_req

    task automatic trap();
        @(posedge i_clk);
        #1 o_trap_n = 1'b0;
        repeat (10) @(posedge i_clk);
        #1 o_trap_n = 1'b1;
        repeat (10) @(posedge i_clk);
    endtask : trap
endmodule : ext_src

// >>> tb/tmr_int_unit_tb_top.sv
// Purpose: directed bench for the timer and priority interrupt unit
// Assumes: 25 MHz clock, inputs driven 1 ns after the rising edge
// Notes:   timer priority kept within 0..6 except for the deliberate seven case
`timescale 1ns/1ps
module tmr_int_unit_tb_top import tmr_int_pkg::*;;
    logic i_clk, i_nrst, tick_n, trap_n, sreg_wr, sreg_rd, clr_bit, boundary, no_intr, in_check;
    logic restore, par_err, tmo, stall, take, load_ps, mcheck;
    logic [NUM_LEVELS-1:0] req_n;
    logic [3:0]            sreg_num;
    logic [31:0]           wdata, rdata;
    logic [4:0]            clr_pos;
    logic [2:0]            take_lvl;
    logic [15:0]           ctrl;
    prog_status_s          cur_ps, new_ps, rst_ps, old_ps, load_val;
    int fail_count, num_checks, take_cnt, stall_cnt, mc_cnt, n_ticks;
    logic [3:0] rnum [6] = '{4'h6, 4'h7, 4'h8, 4'hc, 4'he, 4'h3};

    tmr_int_unit dut_u (.i_clk(i_clk), .i_nrst(i_nrst), .i_tick_n(tick_n), .i_req_n(req_n),
        .i_trap_n(trap_n), .i_chan_parity_err(par_err), .i_chan_timeout(tmo),
        .i_sreg_wr(sreg_wr), .i_sreg_rd(sreg_rd), .i_sreg_num(sreg_num), .i_sreg_wdata(wdata),
        .i_clr_bit(clr_bit), .i_clr_pos(clr_pos), .o_sreg_rdata(rdata), .i_boundary(boundary),
        .i_no_intr(no_intr), .i_in_check(in_check), .i_cur_ps(cur_ps), .i_new_ps(new_ps),
        .i_restore(restore), .i_restore_ps(rst_ps), .o_stall(stall), .o_take(take),
        .o_take_level(take_lvl), .o_old_ps(old_ps), .o_load_ps(load_ps),
        .o_load_ps_val(load_val), .o_mcheck(mcheck), .o_ctrl_word(ctrl));
    ext_src src_u (.i_clk(i_clk), .o_tick_n(tick_n), .o_req_n(req_n), .o_trap_n(trap_n));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        if (take === 1'b1) take_cnt++;
        if (stall === 1'b1) stall_cnt++;
        if (mcheck === 1'b1) mc_cnt++;
    end
    task automatic edge1();
        @(posedge i_clk);
        #1;
    endtask : edge1
    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : check
    task automatic wr(input logic [3:0] n, input logic [31:0] d);
        edge1();
        sreg_num = n;
        wdata = d;
        sreg_wr = 1'b1;
        edge1();
        sreg_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] n, input logic [31:0] exp, input string nm);
        edge1();
        sreg_num = n;
        sreg_rd = 1'b1;
        edge1();
        sreg_rd = 1'b0;
        check(nm, exp, rdata);
    endtask : rd
    task automatic clr(input logic [3:0] n, input logic [4:0] p);
        edge1();
        sreg_num = n;
        clr_pos = p;
        clr_bit = 1'b1;
        edge1();
        clr_bit = 1'b0;
    endtask : clr
    task automatic tick();
        n_ticks++;
        src_u.tick();
    endtask : tick
    task automatic wait_take(input logic [2:0] lvl);
        int t0;
        t0 = take_cnt;
        for (int i = 0; i < 20 && take_cnt == t0; i++) edge1();
        check("take count", 32'(t0 + 1), 32'(take_cnt));
        check("take level", {29'h0, lvl}, {29'h0, take_lvl});
    endtask : wait_take
    task automatic no_take();
        int t0;
        t0 = take_cnt;
        repeat (6) edge1();
        check("no take", 32'(t0), 32'(take_cnt));
    endtask : no_take
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : print_verdict

    // the whole sequence needs under 1500 cycles; this leaves wide margin
    initial begin
        #(40 * 20000);
        fail_count++;
        print_verdict();
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        {i_nrst, sreg_wr, sreg_rd, clr_bit, boundary, no_intr, in_check, restore} = '0;
        {par_err, tmo, sreg_num, wdata, clr_pos} = '0;
        cur_ps = '{32'h0000_1234, 16'h00a5, 16'h0000};
        new_ps = '{32'h0000_0800, 16'h0000, 16'h0101};
        rst_ps = '{32'h0000_1234, 16'h00a5, 16'h0003};
        repeat (10) @(posedge i_clk);
        #1 i_nrst = 1'b1;
        foreach (rnum[i]) rd(rnum[i], 32'h0, "reset value");
        wr(SREG_COUNTDOWN, 32'h2);
        wr(SREG_RELOAD, 32'h5);
        rd(SREG_COUNTDOWN, 32'h2, "countdown after reload write");
        wr(SREG_TSTATUS, 32'h42);
        tick();
        tick();
        rd(SREG_COUNTDOWN, 32'h5, "reload on expiry");
        rd(SREG_RELOAD, 32'h5, "reload kept");
        rd(SREG_TSTATUS, 32'h62, "pending set");
        rd(SREG_REQ_BUF, 32'h2000, "timer request");
        repeat (5) tick();
        rd(SREG_TSTATUS, 32'h72, "overflow set");
        clr(SREG_TSTATUS, 5'd26);
        rd(SREG_TSTATUS, 32'h52, "pending cleared");
        clr(SREG_TSTATUS, 5'd27);
        rd(SREG_TSTATUS, 32'h42, "overflow cleared");
        wr(SREG_REQ_BUF, 32'h0);
        wr(SREG_TSTATUS, 32'h02);
        wr(SREG_COUNTDOWN, 32'h1);
        tick();
        rd(SREG_COUNTDOWN, 32'h5, "counting while disabled");
        rd(SREG_TSTATUS, 32'h02, "no pending while disabled");
        rd(SREG_REQ_BUF, 32'h0, "no request while disabled");
        wr(SREG_TSTATUS, 32'h47);
        wr(SREG_COUNTDOWN, 32'h1);
        tick();
        rd(SREG_REQ_BUF, 32'h0, "priority seven");
        rd(SREG_TSTATUS, 32'h67, "pending at priority seven");
        wr(SREG_CTRL_WORD, 32'h0103);
        wr(SREG_REQ_BUF, 32'h4000);
        edge1();
        boundary = 1'b1;
        no_take();
        rd(SREG_REQ_BUF, 32'h4000, "masked request pending");
        wr(SREG_CTRL_WORD, 32'h0003);
        wait_take(3'h1);
        check("old iar", 32'h0000_1234, old_ps.instr_ptr);
        check("old ctrl", 32'h0000_0003, {16'h0, old_ps.ctrl_word});
        check("new iar", 32'h0000_0800, load_val.instr_ptr);
        check("new ctrl", 32'h0000_0101, {16'h0, ctrl});
        edge1();
        boundary = 1'b0;
        restore = 1'b1;
        edge1();
        restore = 1'b0;
        check("restored ctrl", 32'h0000_0003, {16'h0, ctrl});
        check("restored iar", 32'h0000_1234, load_val.instr_ptr);
        // line first: its synchroniser needs four edges before the boundary opens
        src_u.set_req(7'h6f);
        wr(SREG_REQ_BUF, 32'h0400);
        wr(SREG_CTRL_WORD, 32'h0006);
        edge1();
        boundary = 1'b1;
        wait_take(3'h4);
        wr(SREG_CTRL_WORD, 32'h0004);
        no_take();
        edge1();
        no_intr = 1'b1;
        wr(SREG_CTRL_WORD, 32'h0005);
        no_take();
        edge1();
        no_intr = 1'b0;
        in_check = 1'b1;
        no_take();
        edge1();
        in_check = 1'b0;
        wait_take(3'h4);
        edge1();
        boundary = 1'b0;
        par_err = 1'b1;
        edge1();
        par_err = 1'b0;
        tmo = 1'b1;
        edge1();
        tmo = 1'b0;
        src_u.trap();
        check("machine checks", 32'h3, 32'(mc_cnt));
        check("stall cycles", 32'(2 * n_ticks), 32'(stall_cnt));
        print_verdict();
    end
endmodule : tmr_int_unit_tb_top

bind tmr_int_unit tmr_int_unit_chk chk_u (.i_clk, .i_nrst, .i_boundary, .i_no_intr,
    .i_in_check, .i_restore, .i_chan_parity_err, .i_chan_timeout, .i_cur_ps, .i_new_ps,
    .i_restore_ps, .o_stall, .o_take, .o_take_level, .o_old_ps, .o_load_ps, .o_load_ps_val,
    .o_mcheck, .o_ctrl_word);
